// ===== hw/cabi_bus_master.v
// bus master side of the cpu async bus interface
// Function
// R1: word address out, iack level, upper ones
// R2: iack vector returns on low data byte
// R3: address strobe only with valid address
// R4: read high, write low direction line
// R5: byte strobes select valid data lanes
// R6: byte write duplicated on both lanes
// R7: ack latches read data, ends cycle
// R8: other masters request on shared line
// R9: grant out, release after current cycle
// R10: grant ack only after four conditions
// R11: three level inputs, seven highest
// R12: bus fault with halt: retry or exception
// R13: external reset inits; reset op drives out
// R14: halt plus reset resets whole system
// R15: external halt stops after cycle, floats
// R16: device drives halt when stopped
// R17: enable period ten, six low four high
// R18: sync select syncs to enable; autovector
// R19: sync valid only after sync select
// R20: cycle type code valid with strobe
// R21: only five defined cycle type codes
// R22: byte select zero upper, one lower
// R23: hold cycle until ack or fault
`include "cabi_regs.vh"
module cabi_bus_master (
  input  wire        ref_clk,
  input  wire        arst_n,
  input  wire        req_valid,
  input  wire        req_write,
  input  wire        req_byte,
  input  wire        req_iack,
  input  wire        req_super,
  input  wire        req_program,
  input  wire [23:0] req_addr,
  input  wire [15:0] req_wdata,
  input  wire        req_reset_ext,
  input  wire        req_stop,
  output reg         req_ready,
  output reg         rsp_valid,
  output reg  [15:0] rsp_rdata,
  output reg         rsp_fault,
  output reg         rsp_autovec,
  output reg  [2:0]  irq_level,
  output reg         reset_seen,
  output reg  [22:0] addr_out,
  output reg         addr_oe_n,
  input  wire [15:0] data_in,
  output reg  [15:0] data_out,
  output reg         data_oe_n,
  output reg         addr_strobe_n,
  output reg         read_write,
  output reg         upper_byte_strobe_n,
  output reg         lower_byte_strobe_n,
  output reg         ctrl_oe_n,
  input  wire        xfer_ack_n,
  input  wire        bus_req_n,
  output reg         bus_grant_n,
  input  wire        grant_ack_n,
  input  wire [2:0]  irq_level_n,
  input  wire        bus_fault_n,
  input  wire        reset_in_n,
  output reg         reset_out,
  output reg         reset_oe_n,
  input  wire        halt_in_n,
  output reg         halt_out,
  output reg         halt_oe_n,
  output reg         periph_enable,
  input  wire        sync_periph_sel_n,
  output reg         sync_addr_valid_n,
  output reg  [2:0]  cycle_type_code
);
  localparam ST_IDLE  = 3'h0;
  localparam ST_ADDR  = 3'h1;
  localparam ST_WAIT  = 3'h2;
  localparam ST_SYNC  = 3'h3;
  localparam ST_END   = 3'h4;
  localparam ST_GRANT = 3'h5;
  localparam ST_HALT  = 3'h6;
  localparam ST_STOP  = 3'h7;

  wire       e_int;
  wire [3:0] e_phase;
  reg  [2:0] state_q;
  reg  [7:0] rst_cnt_q;
  reg        retry_q;
  reg        rmw_wr_q;
  reg        byte_q;
  reg        lane_q;
  // fault is kept here, so a pulse that ends before the reply still counts
  reg        fault_q;

  cabi_enable_gen u_enable (
    .ref_clk       (ref_clk),
    .arst_n        (arst_n),
    .periph_enable (e_int),
    .phase         (e_phase)
  );

  // only the five defined codes can come out
  function [2:0] fc_code;
    input iack;
    input sup;
    input prog;
    begin
      if (iack) begin
        fc_code = `CABI_FC_IACK; // see R21
      end else if (sup) begin
        fc_code = prog ? `CABI_FC_SPROG : `CABI_FC_SDATA;
      end else begin
        fc_code = prog ? `CABI_FC_UPROG : `CABI_FC_UDATA;
      end
    end
  endfunction

  wire ext_halt = !halt_in_n && halt_oe_n;
  wire ext_rst  = !reset_in_n && reset_oe_n;
  wire acked    = !xfer_ack_n;
  wire faulted  = !bus_fault_n;

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q             <= ST_IDLE;
      rst_cnt_q           <= 8'h00;
      retry_q             <= 1'b0;
      rmw_wr_q            <= 1'b0;
      fault_q             <= 1'b0;
      req_ready           <= 1'b0;
      rsp_valid           <= 1'b0;
      rsp_rdata           <= 16'h0000;
      rsp_fault           <= 1'b0;
      rsp_autovec         <= 1'b0;
      irq_level           <= 3'h0;
      reset_seen          <= 1'b0;
      addr_out            <= 23'h00_0000;
      addr_oe_n           <= 1'b1;
      data_out            <= 16'h0000;
      data_oe_n           <= 1'b1;
      addr_strobe_n       <= 1'b1;
      read_write          <= 1'b1;
      upper_byte_strobe_n <= 1'b1;
      lower_byte_strobe_n <= 1'b1;
      ctrl_oe_n           <= 1'b1;
      bus_grant_n         <= 1'b1;
      reset_out           <= 1'b0;
      reset_oe_n          <= 1'b1;
      halt_out            <= 1'b0;
      halt_oe_n           <= 1'b1;
      periph_enable       <= 1'b0;
      sync_addr_valid_n   <= 1'b1;
      cycle_type_code     <= 3'h0;
    end else begin
      periph_enable <= e_int;
      irq_level     <= ~irq_level_n; // see R11
      rsp_valid     <= 1'b0;
      req_ready     <= 1'b0;
      reset_seen    <= ext_rst; // see R13 see R14
      // reset operation drives the line for a fixed pulse, internal state kept
      if (rst_cnt_q != 8'h00) begin
        rst_cnt_q <= rst_cnt_q - 8'h01;
      end else if (req_reset_ext) begin
        rst_cnt_q <= `CABI_RST_PULSE_CYC; // see R13
      end
      reset_out  <= 1'b0;
      reset_oe_n <= !(rst_cnt_q != 8'h00 || (req_reset_ext && rst_cnt_q == 8'h00));
      if (ext_rst) begin
        state_q             <= ST_IDLE;
        addr_strobe_n       <= 1'b1;
        upper_byte_strobe_n <= 1'b1;
        lower_byte_strobe_n <= 1'b1;
        ctrl_oe_n           <= 1'b1;
        addr_oe_n           <= 1'b1;
        data_oe_n           <= 1'b1;
        sync_addr_valid_n   <= 1'b1;
        halt_oe_n           <= 1'b1;
        bus_grant_n         <= 1'b1;
      end else begin
        case (state_q)
          ST_IDLE: begin
            if (!bus_req_n || !grant_ack_n) begin
              bus_grant_n <= bus_req_n; // see R9
              state_q     <= ST_GRANT;
            end else if (ext_halt) begin
              ctrl_oe_n <= 1'b1; // see R15
              addr_oe_n <= 1'b1;
              data_oe_n <= 1'b1;
              state_q   <= ST_HALT;
            end else if (req_stop) begin
              state_q <= ST_STOP;
            end else if (req_valid) begin
              // see R1
              addr_out  <= req_iack ? {`CABI_IACK_UPPER, irq_level} : req_addr[23:1];
              addr_oe_n <= 1'b0;
              ctrl_oe_n <= 1'b0;
              read_write <= !req_write; // see R4
              cycle_type_code <= fc_code(req_iack, req_super, req_program); // see R20
              data_out <= req_byte ? {2{req_addr[0] ? req_wdata[7:0] : req_wdata[15:8]}}
                                   : req_wdata; // see R6
              rmw_wr_q <= req_write;
              rsp_autovec <= 1'b0;
              req_ready <= 1'b1;
              state_q   <= ST_ADDR;
            end
          end
          ST_ADDR: begin
            addr_strobe_n <= 1'b0; // see R3
            data_oe_n     <= !rmw_wr_q;
            // see R5 see R22
            // a word cycle asserts both strobes, a byte cycle only its lane
            upper_byte_strobe_n <= byte_q && lane_q;
            lower_byte_strobe_n <= byte_q && !lane_q;
            state_q <= ST_WAIT;
          end
          ST_WAIT: begin
            if (!sync_periph_sel_n) begin
              state_q <= ST_SYNC; // see R18
            end else if (faulted) begin
              retry_q <= ext_halt; // see R12
              fault_q <= 1'b1;
              state_q <= ST_END;
            end else if (acked) begin
              rsp_rdata <= read_write ? data_in : rsp_rdata; // see R7
              retry_q   <= 1'b0;
              fault_q   <= 1'b0;
              state_q   <= ST_END;
            end // see R23
          end
          ST_SYNC: begin
            // wait for enable phase 2, inside the enable low phase, before valid
            if (e_phase == 4'h2) begin
              sync_addr_valid_n <= 1'b0; // see R19
            end
            if (!sync_addr_valid_n && e_phase == `CABI_E_PERIOD) begin
              rsp_autovec <= (cycle_type_code == `CABI_FC_IACK);
              rsp_rdata   <= read_write ? data_in : rsp_rdata;
              fault_q     <= 1'b0;
              state_q     <= ST_END;
            end else if (faulted) begin
              retry_q <= ext_halt;
              fault_q <= 1'b1;
              state_q <= ST_END;
            end
          end
          ST_END: begin
            addr_strobe_n       <= 1'b1;
            upper_byte_strobe_n <= 1'b1;
            lower_byte_strobe_n <= 1'b1;
            sync_addr_valid_n   <= 1'b1;
            data_oe_n           <= 1'b1;
            if (retry_q) begin
              // float the bus while halted; retry re-drives it afterwards
              ctrl_oe_n <= 1'b1; // see R15
              addr_oe_n <= 1'b1;
              state_q   <= ST_HALT; // see R12
            end else begin
              rsp_valid <= 1'b1;
              rsp_fault <= fault_q;
              state_q   <= ST_IDLE;
            end
          end
          ST_GRANT: begin
            ctrl_oe_n <= 1'b1;
            addr_oe_n <= 1'b1;
            if (!grant_ack_n) begin
              bus_grant_n <= 1'b1; // see R10
            end else if (bus_req_n) begin
              bus_grant_n <= 1'b1;
              state_q     <= ST_IDLE;
            end
          end
          ST_HALT: begin
            if (!ext_halt) begin
              state_q <= retry_q ? ST_ADDR : ST_IDLE;
              ctrl_oe_n <= !retry_q;
              addr_oe_n <= !retry_q;
              retry_q   <= 1'b0;
            end
          end
          ST_STOP: begin
            halt_oe_n <= 1'b0; // see R16
            halt_out  <= 1'b0;
          end
          default: begin
            state_q <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // byte size and lane kept from the accepted request, so a retried
  // cycle after halt asserts the same strobes again
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      byte_q <= 1'b0;
      lane_q <= 1'b0;
    end else if (state_q == ST_IDLE && req_valid) begin
      byte_q <= req_byte;
      lane_q <= req_addr[0];
    end
  end
endmodule

// ===== hw/cabi_enable_gen.v
// free-running peripheral enable generator
`include "cabi_regs.vh"
module cabi_enable_gen (
  input  wire       ref_clk,
  input  wire       arst_n,
  output reg        periph_enable,
  output reg  [3:0] phase
);
  // six low then four high per ten clocks
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      phase         <= 4'h0;
      periph_enable <= 1'b0;
    end else begin
      if (phase == `CABI_E_PERIOD) begin
        phase <= 4'h0;
      end else begin
        phase <= phase + 4'h1;
      end
      // see R17
      periph_enable <= (phase >= (`CABI_E_LOW_CYCLES - 4'h1)) && (phase != `CABI_E_PERIOD);
    end
  end
endmodule

// ===== hw/cabi_regs.vh
// constants for the cpu async bus interface
`ifndef CABI_REGS_VH
`define CABI_REGS_VH
`define CABI_ADDR_W         23
`define CABI_DATA_W         16
`define CABI_FC_UDATA       3'h1
`define CABI_FC_UPROG       3'h2
`define CABI_FC_SDATA       3'h5
`define CABI_FC_SPROG       3'h6
`define CABI_FC_IACK        3'h7
`define CABI_E_PERIOD       4'h9
`define CABI_E_LOW_CYCLES   4'h6
`define CABI_E_HIGH_CYCLES  4'h4
`define CABI_IACK_UPPER     20'hF_FFFF
`define CABI_RST_PULSE_CYC  8'h7C
`endif

// ===== tb/cabi_props.sv
// pin-level assertions for the bus master
module cabi_props (
  input wire logic        ref_clk,
  input wire logic        arst_n,
  input wire logic [22:0] addr_out,
  input wire logic        addr_oe_n,
  input wire logic        data_oe_n,
  input wire logic        addr_strobe_n,
  input wire logic        read_write,
  input wire logic        xfer_ack_n,
  input wire logic        bus_fault_n,
  input wire logic        periph_enable,
  input wire logic        sync_addr_valid_n,
  input wire logic [2:0]  cycle_type_code
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  sequence s_en_cycle;
    (!periph_enable)[*6] ##1 periph_enable[*4] ##1 !periph_enable;
  endsequence
  sequence s_ack_seen;
    !addr_strobe_n && !xfer_ack_n;
  endsequence
  a_strobe_has_addr: assert property (!addr_strobe_n |-> !addr_oe_n)
    else $error("strobe without driven address");
  a_enable_period: assert property ($fell(periph_enable) |-> s_en_cycle)
    else $error("enable period wrong");
  a_code_defined: assert property (!addr_strobe_n |->
    cycle_type_code inside {3'h1, 3'h2, 3'h5, 3'h6, 3'h7})
    else $error("reserved cycle type code");
  a_iack_upper_ones: assert property (!addr_strobe_n && cycle_type_code == 3'h7
    |-> &addr_out[22:3])
    else $error("iack upper address not high");
  a_wait_hold: assert property (!addr_strobe_n && xfer_ack_n && bus_fault_n && sync_addr_valid_n
    |=> $stable(addr_out) && !addr_strobe_n)
    else $error("cycle dropped before ack");
  a_write_dir: assert property (!data_oe_n |-> !read_write)
    else $error("data driven in read cycle");
  a_ack_ends: assert property (s_ack_seen |-> ##[1:4] addr_strobe_n)
    else $error("cycle not ended after ack");
  a_sync_valid: assert property (!sync_addr_valid_n |-> !addr_strobe_n)
    else $error("sync valid without address");
endmodule
bind cabi_bus_master cabi_props i_props (.*);

// ===== tb/cabi_slave_mem.sv
// behavioural memory slave with vector response
module cabi_slave_mem (
  input wire logic        ref_clk,
  input wire logic [22:0] addr_out,
  input wire logic [15:0] data_out,
  input wire logic        addr_strobe_n,
  input wire logic        upper_byte_strobe_n,
  input wire logic        lower_byte_strobe_n,
  input wire logic        read_write,
  input wire logic [2:0]  cycle_type_code,
  input wire logic        mute,
  input wire logic [3:0]  wait_cyc,
  output logic            xfer_ack_n,
  output logic     [15:0] data_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] mem [16] = '{default: 16'h0000};
  logic [3:0]  cnt = 4'h0;
  wire [3:0]   ix = addr_out[3:0];
  wire [15:0]  lane = {{8{upper_byte_strobe_n}}, {8{lower_byte_strobe_n}}};
  initial xfer_ack_n = 1'b1;
  initial data_in = 16'h0000;
  always @(posedge ref_clk) begin
    if (addr_strobe_n) begin
      xfer_ack_n <= 1'b1;
      cnt <= 4'h0;
      data_in <= ~data_in; // released bus must not keep its last value
    end else if ((!upper_byte_strobe_n || !lower_byte_strobe_n) && xfer_ack_n && !mute) begin
      if (cnt < wait_cyc) begin
        cnt <= cnt + 4'h1;
      end else begin
        xfer_ack_n <= 1'b0;
        if (cycle_type_code == 3'h7) begin
          data_in <= 16'hBD42;
        end else if (read_write) begin
          data_in <= mem[ix] ^ lane;
        end else begin
          if (!upper_byte_strobe_n) mem[ix][15:8] <= data_out[15:8];
          if (!lower_byte_strobe_n) mem[ix][7:0] <= data_out[7:0];
        end
      end
    end
  end
endmodule

// ===== tb/testbench.sv
// self-checking bench for the bus master
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin n_fail++; \
  $display("[FAIL] %s exp %h got %h", n, e, a); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        ref_clk = 0, arst_n = 0, req_valid = 0, req_write = 0, req_byte = 0;
  logic        req_iack = 0, req_super = 0, req_program = 0, req_reset_ext = 0;
  logic        req_stop = 0, mute = 0, bus_req_n = 1, grant_ack_n = 1, bus_fault_n = 1;
  logic        reset_in_n = 1, halt_in_n = 1, sync_periph_sel_n = 1;
  logic [23:0] req_addr = 0;
  logic [15:0] req_wdata = 0, rd;
  logic [2:0]  irq_level_n = 3'h7;
  logic [3:0]  wait_cyc = 0;
  logic        flt;
  int          n_fail = 0, checks = 0, k;
  wire         req_ready, rsp_valid, rsp_fault, xfer_ack_n, addr_strobe_n, read_write;
  wire         upper_byte_strobe_n, lower_byte_strobe_n, bus_grant_n, periph_enable;
  wire         rsp_autovec, reset_seen, halt_oe_n, reset_oe_n;
  wire  [15:0] rsp_rdata, data_in, data_out;
  wire  [22:0] addr_out;
  wire  [2:0]  irq_level, cycle_type_code;
  always #20 ref_clk = ~ref_clk;
  cabi_bus_master i_dut (.*, .addr_oe_n(), .data_oe_n(),
    .ctrl_oe_n(), .reset_out(), .halt_out(), .sync_addr_valid_n());
  cabi_slave_mem i_mem (.*);
  task automatic end_sim();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // one local request, held until taken, then wait for the answer
  task automatic xfer(input logic w, b, i, input logic [23:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    req_valid <= 1'b1;
    {req_write, req_byte, req_iack, req_addr, req_wdata} <= {w, b, i, a, d};
    k = 0;
    do @(posedge ref_clk); while (req_ready !== 1'b1 && ++k < 300);
    req_valid <= 1'b0;
    do @(posedge ref_clk); while (rsp_valid !== 1'b1 && ++k < 600);
    rd = rsp_rdata;
    flt = rsp_fault;
  endtask
  task automatic t_word();
    for (int m = 0; m < 4; m++) begin
      {req_super, req_program} <= 2'(m);
      wait_cyc <= 4'(m * 3); // slow slave stretches the cycle
      xfer(1, 0, 0, 24'(m * 2), 16'hA5C0 + 16'(m));
      xfer(0, 0, 0, 24'(m * 2), 16'h0000);
      `CHK("word", 16'hA5C0 + 16'(m), rd)
    end
  endtask
  task automatic t_bytes();
    xfer(1, 1, 0, 24'h00_0006, 16'h7E7E);
    xfer(1, 1, 0, 24'h00_0007, 16'h8181);
    xfer(0, 0, 0, 24'h00_0006, 16'h0000);
    `CHK("lanes", 16'h7E81, rd)
  endtask
  task automatic t_iack();
    irq_level_n <= 3'h2;
    k = 0;
    do @(posedge ref_clk); while (irq_level !== 3'h5 && ++k < 20);
    `CHK("level", 3'h5, irq_level)
    xfer(0, 0, 1, 24'h00_000A, 16'h0000);
    `CHK("vector", 8'h42, rd[7:0])
    irq_level_n <= 3'h7;
  endtask
  task automatic t_fault();
    mute <= 1'b1;
    bus_fault_n <= 1'b0; // no responder, external logic flags the cycle
    xfer(0, 0, 0, 24'h00_0010, 16'h0000);
    `CHK("fault", 1'b1, flt)
    mute <= 1'b0;
    bus_fault_n <= 1'b1;
  endtask
  task automatic t_grant();
    bus_req_n <= 1'b0;
    k = 0;
    do @(posedge ref_clk); while (bus_grant_n !== 1'b0 && ++k < 100);
    `CHK("grant", 1'b0, bus_grant_n)
    do @(posedge ref_clk); while ((addr_strobe_n & xfer_ack_n) !== 1'b1 && ++k < 200);
    grant_ack_n <= 1'b0;
    bus_req_n <= 1'b1;
    repeat (6) @(posedge ref_clk);
    `CHK("bus idle", 1'b1, addr_strobe_n)
    `CHK("grant released", 1'b1, bus_grant_n)
    grant_ack_n <= 1'b1;
  endtask
  task automatic t_sync();
    sync_periph_sel_n <= 1'b0;
    mute <= 1'b1; // only the enable timing can end this cycle
    xfer(0, 0, 1, 24'h00_000C, 16'h0000);
    `CHK("autovector", 1'b1, rsp_autovec)
    `CHK("sync fault", 1'b0, flt)
    sync_periph_sel_n <= 1'b1;
    mute <= 1'b0;
  endtask
  task automatic t_system();
    req_stop <= 1'b1;
    @(posedge ref_clk);
    req_stop <= 1'b0;
    repeat (3) @(posedge ref_clk);
    `CHK("stop drives halt", 1'b0, halt_oe_n)
    halt_in_n <= 1'b0;
    reset_in_n <= 1'b0;
    repeat (3) @(posedge ref_clk);
    `CHK("system reset", 1'b1, reset_seen)
    `CHK("halt released", 1'b1, halt_oe_n)
    halt_in_n <= 1'b1;
    reset_in_n <= 1'b1;
    @(posedge ref_clk);
    req_reset_ext <= 1'b1;
    @(posedge ref_clk);
    req_reset_ext <= 1'b0;
    repeat (3) @(posedge ref_clk);
    `CHK("reset op drives", 1'b0, reset_oe_n)
  endtask
  task automatic t_enable();
    k = 0;
    repeat (20) begin
      @(posedge ref_clk);
      k += int'(periph_enable === 1'b1);
    end
    `CHK("enable high", 8, k)
  endtask
  initial begin
    #200000;
    n_fail++;
    end_sim();
  end
  initial begin
    repeat (2) @(posedge ref_clk);
    arst_n <= 1'b1;
    t_word();
    t_bytes();
    t_iack();
    t_fault();
    t_grant();
    t_enable();
    t_sync();
    t_system();
    end_sim();
  end
endmodule
